// ===== logic/gateway_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts for the serial gateway.
// Assumes: Included by the package and by every design file that needs a figure.
// Notes: Definitions only.
`ifndef GATEWAY_REGS_SVH
`define GATEWAY_REGS_SVH

// Clock and line timing
`define CLK_HZ 125000000
`define BAUD_DEFAULT 9600
`define OVERSAMPLE 16
`define BAUD_DIV_DEFAULT ((`CLK_HZ + (`BAUD_DEFAULT * `OVERSAMPLE) / 2) / (`BAUD_DEFAULT * `OVERSAMPLE))
`define OS_MID 4'h7
`define OS_LAST 4'hF
`define FRAME_LAST 4'h9

// Buffer sizes and image width
`define RX_DEPTH 128
`define TX_DEPTH 16
`define IMG_BYTES 3

// Control byte fields
`define CTL_TX_REQ 0
`define CTL_RX_ACK 1
`define CTL_INIT 2
`define CTL_LEN_LSB 4
`define CTL_LEN_MSB 6

// Status byte fields
`define STS_TX_ACK 0
`define STS_RX_PEND 1
`define STS_INIT_ACK 2
`define STS_FULL 3
`define STS_LEN_LSB 4
`define STS_LEN_MSB 6

// Controller register offsets
`define REG_TX 4'h0
`define REG_RX 4'h4
`define REG_CTL 4'h8
`define REG_STS 4'hC

`endif

// ===== logic/gateway_pkg.sv
// Purpose: Types shared by both ends of the process image link.
// Assumes: Header of constants is on the include path.
// Notes: Holds types only; figures live in the header.
`include "gateway_regs.svh"

package gateway_pkg;
   typedef logic [`IMG_BYTES-1:0][7:0] image_data_type;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_type;
endpackage

// ===== logic/image_if.sv
// Purpose: Process image between the fieldbus master end and the serial gateway.
// Assumes: Both ends run on sys_clk.
// Notes: Three data bytes plus one control or status byte each way.
`timescale 1ns/10ps

interface image_if;
   import gateway_pkg::*;
   image_data_type out_data;
   logic [7:0] ctrl;
   image_data_type in_data;
   logic [7:0] stat;

   modport device (input out_data, input ctrl, output in_data, output stat);
   modport master (output out_data, output ctrl, input in_data, input stat);
endinterface

// ===== logic/baud_tick.sv
// Purpose: Oversampling enable for the serial line.
// Assumes: div is at least 2.
// Notes: One-cycle pulse every div clocks; clear restarts the period.
`timescale 1ns/10ps

module baud_tick (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [15:0] div,
   input wire logic clear,
   output logic tick
);
   logic [15:0] cnt_q;

   // Free counter, wraps at div
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= 16'h0000;
      else if (clear || cnt_q == div - 16'h0001)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end

   assign tick = !clear && (cnt_q == div - 16'h0001);
endmodule

// ===== logic/serial_gateway.sv
// Purpose: Serial gateway end: UART line on one side, process image on the other.
// Assumes: Control byte comes from logic on sys_clk; rx_pin is asynchronous.
// Notes: Half duplex use relies on tx_drive_en for the line driver.
// How it works
// - Line runs at 9600 baud by default
// - One start, eight data, one stop, no parity
// - Received characters held in 128-byte buffer
// - Master characters queued in 16-byte buffer
// - Three data bytes plus control/status each way
// - Request inverts bit; acknowledge copies it
// - At most three received characters presented
// - Control byte layout set by master
// - Status byte layout, bit 7 zero
// - Master loads bytes, length, then toggles request
// - Copy characters, then mirror transmit request
// - Present pending characters, toggle receive request
// - Master reads count, then inverts receive acknowledge
// - Equal receive toggles mean chunk consumed
// - Transmit and receive run independently
// - Init blocks traffic, clears buffers, reloads config
// - Init overrides and aborts transfers at once
// - Init acknowledge low during init, high after
// - Full buffer flagged; further characters dropped
`timescale 1ns/10ps
`include "gateway_regs.svh"

module serial_gateway (
   input wire logic sys_clk,
   input wire logic rst_b,
   image_if.device img,
   input wire logic [15:0] cfg_baud_div,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic tx_drive_en
);
   import gateway_pkg::*;

   logic init_req;
   logic os_tick;
   logic [15:0] baud_div_q;
   logic init_ack_q;

   assign init_req = img.ctrl[`CTL_INIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration and init

   // Divisor reloads while init is held
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         baud_div_q <= 16'(`BAUD_DIV_DEFAULT);
      else if (init_req)
         baud_div_q <= cfg_baud_div;
   end

   // Acknowledge follows the release of the request
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         init_ack_q <= 1'b0;
      else
         init_ack_q <= !init_req;
   end

   baud_tick u_tick (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .div(baud_div_q),
      .clear(init_req),
      .tick(os_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver

   logic rx_meta_q;
   logic rx_sync_q;
   rx_state_type rx_state_q;
   logic [3:0] rx_os_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_shift_q;
   logic rx_push_q;

   // Two stages before the line is looked at
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end
      else
      begin
         rx_meta_q <= rx_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   // Frame decode at 16x; start bit rechecked at mid-bit to reject glitches
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_state_q <= RX_IDLE;
         rx_os_q <= 4'h0;
         rx_bit_q <= 3'h0;
         rx_shift_q <= 8'h00;
         rx_push_q <= 1'b0;
      end
      else if (init_req)
      begin
         rx_state_q <= RX_IDLE;
         rx_push_q <= 1'b0;
      end
      else
      begin
         rx_push_q <= 1'b0;
         if (os_tick)
         begin
            rx_os_q <= rx_os_q + 4'h1;
            case (rx_state_q)
               RX_IDLE:
               begin
                  rx_os_q <= 4'h0;
                  if (!rx_sync_q)
                     rx_state_q <= RX_START;
               end
               RX_START:
                  if (rx_os_q == `OS_MID)
                  begin
                     rx_os_q <= 4'h0;
                     rx_bit_q <= 3'h0;
                     rx_state_q <= rx_sync_q ? RX_IDLE : RX_DATA;
                  end
               RX_DATA:
                  if (rx_os_q == `OS_LAST)
                  begin
                     rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
                     rx_bit_q <= rx_bit_q + 3'h1;
                     if (rx_bit_q == 3'h7)
                        rx_state_q <= RX_STOP;
                  end
               RX_STOP:
                  if (rx_os_q == `OS_LAST)
                  begin
                     rx_state_q <= RX_IDLE;
                     rx_push_q <= rx_sync_q; // Bad stop bit drops the character
                  end
               default:
                  rx_state_q <= RX_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive buffer and receive handshake

   logic [7:0] rx_mem [`RX_DEPTH];
   logic [6:0] rx_wp_q;
   logic [6:0] rx_rp_q;
   logic [7:0] rx_cnt_q;
   logic rx_full;
   logic rx_take;
   logic rx_present;
   logic [1:0] rx_pop_n;
   image_data_type rx_head;
   image_data_type in_data_q;
   logic [2:0] in_len_q;
   logic rx_pend_q;

   assign rx_full = (rx_cnt_q == 8'(`RX_DEPTH));
   assign rx_take = rx_push_q && !rx_full && !init_req;
   // New chunk only after master equalised the toggles
   assign rx_present = !init_req && (rx_pend_q == img.ctrl[`CTL_RX_ACK]) &&
      (rx_cnt_q != 8'h00);
   assign rx_pop_n = (rx_cnt_q > 8'h03) ? 2'h3 : rx_cnt_q[1:0];

   // Oldest three entries, read side by side
   generate
      for (genvar g = 0; g < `IMG_BYTES; g++)
      begin : g_head
         assign rx_head[g] = rx_mem[rx_rp_q + 7'(g)];
      end
   endgenerate

   // Storage write
   always_ff @(posedge sys_clk)
   begin
      if (rx_take)
         rx_mem[rx_wp_q] <= rx_shift_q;
   end

   // Pointers and fill level; push and pop may share a cycle
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_wp_q <= 7'h00;
         rx_rp_q <= 7'h00;
         rx_cnt_q <= 8'h00;
      end
      else if (init_req)
      begin
         rx_wp_q <= 7'h00;
         rx_rp_q <= 7'h00;
         rx_cnt_q <= 8'h00;
      end
      else
      begin
         if (rx_take)
            rx_wp_q <= rx_wp_q + 7'h01;
         if (rx_present)
            rx_rp_q <= rx_rp_q + 7'(rx_pop_n);
         rx_cnt_q <= rx_cnt_q + 8'(rx_take) - (rx_present ? 8'(rx_pop_n) : 8'h00);
      end
   end

   // Input bytes change only together with the receive request toggle
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         in_data_q <= '0;
         in_len_q <= 3'h0;
         rx_pend_q <= 1'b0;
      end
      else if (rx_present)
      begin
         for (int k = 0; k < `IMG_BYTES; k++)
            in_data_q[k] <= (2'(k) < rx_pop_n) ? rx_head[k] : 8'h00;
         in_len_q <= {1'b0, rx_pop_n};
         rx_pend_q <= !rx_pend_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit handshake and transmit buffer

   logic [7:0] tx_mem [`TX_DEPTH];
   logic [3:0] tx_wp_q;
   logic [3:0] tx_rp_q;
   logic [4:0] tx_cnt_q;
   logic [2:0] out_len;
   logic [2:0] tx_n;
   logic tx_take;
   logic tx_pop;
   logic tx_ack_q;
   tx_state_type tx_state_q;
   logic [3:0] tx_os_q;
   logic [3:0] tx_bitn_q;
   logic [9:0] tx_frame_q;

   assign out_len = img.ctrl[`CTL_LEN_MSB:`CTL_LEN_LSB];
   assign tx_n = (out_len > 3'h3) ? 3'h3 : out_len; // Longer lengths clipped to the image
   // Chunk waits for room rather than losing characters
   assign tx_take = !init_req && (img.ctrl[`CTL_TX_REQ] != tx_ack_q) &&
      ((6'(tx_cnt_q) + 6'(tx_n)) <= 6'(`TX_DEPTH));
   assign tx_pop = !init_req && (tx_state_q == TX_IDLE) && (tx_cnt_q != 5'h00);

   // Up to three characters stored in one cycle
   always_ff @(posedge sys_clk)
   begin
      if (tx_take)
         for (int k = 0; k < `IMG_BYTES; k++)
            if (3'(k) < tx_n)
               tx_mem[tx_wp_q + 4'(k)] <= img.out_data[k];
   end

   // Acknowledge mirrors the request once characters are stored
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         tx_ack_q <= 1'b0;
      else if (tx_take)
         tx_ack_q <= img.ctrl[`CTL_TX_REQ];
   end

   // Pointers and fill level
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_wp_q <= 4'h0;
         tx_rp_q <= 4'h0;
         tx_cnt_q <= 5'h00;
      end
      else if (init_req)
      begin
         tx_wp_q <= 4'h0;
         tx_rp_q <= 4'h0;
         tx_cnt_q <= 5'h00;
      end
      else
      begin
         if (tx_take)
            tx_wp_q <= tx_wp_q + 4'(tx_n);
         if (tx_pop)
            tx_rp_q <= tx_rp_q + 4'h1;
         tx_cnt_q <= tx_cnt_q + (tx_take ? 5'(tx_n) : 5'h00) - 5'(tx_pop);
      end
   end

   // Serializer: start, eight data LSB first, stop
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_state_q <= TX_IDLE;
         tx_os_q <= 4'h0;
         tx_bitn_q <= 4'h0;
         tx_frame_q <= 10'h3FF;
      end
      else if (init_req)
      begin
         tx_state_q <= TX_IDLE;
         tx_frame_q <= 10'h3FF;
      end
      else
      begin
         case (tx_state_q)
            TX_IDLE:
               if (tx_pop)
               begin
                  tx_frame_q <= {1'b1, tx_mem[tx_rp_q], 1'b0};
                  tx_os_q <= 4'h0;
                  tx_bitn_q <= 4'h0;
                  tx_state_q <= TX_SHIFT;
               end
            TX_SHIFT:
               if (os_tick)
               begin
                  tx_os_q <= tx_os_q + 4'h1;
                  if (tx_os_q == `OS_LAST)
                  begin
                     tx_frame_q <= {1'b1, tx_frame_q[9:1]};
                     tx_bitn_q <= tx_bitn_q + 4'h1;
                     if (tx_bitn_q == `FRAME_LAST)
                        tx_state_q <= TX_IDLE;
                  end
               end
            default:
               tx_state_q <= TX_IDLE;
         endcase
      end
   end

   assign tx_pin = tx_frame_q[0];
   assign tx_drive_en = (tx_state_q == TX_SHIFT);

   ////////////////////////////////////////////////////////////////////////////////
   // Status byte to the master

   assign img.in_data = in_data_q;
   assign img.stat = {1'b0, in_len_q, rx_full, init_ack_q, rx_pend_q, tx_ack_q};
endmodule

// ===== logic/image_master.sv
// Purpose: Fieldbus master end: drives the control byte and output bytes from registers.
// Assumes: Software port on sys_clk; read data valid the cycle after the read strobe.
// Notes: Transmit writes while a chunk is outstanding are ignored.
`timescale 1ns/10ps
`include "gateway_regs.svh"

module image_master (
   input wire logic sys_clk,
   input wire logic rst_b,
   image_if.master img,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import gateway_pkg::*;

   image_data_type out_data_q;
   logic [2:0] out_len_q;
   logic tx_req_q;
   logic rx_ack_q;
   logic init_q;
   logic tx_load_q;
   logic tx_free;
   logic rx_avail;
   logic [7:0] ctrl;

   assign tx_free = (tx_req_q == img.stat[`STS_TX_ACK]) && !tx_load_q;
   assign rx_avail = (img.stat[`STS_RX_PEND] != rx_ack_q);
   assign ctrl = {1'b0, out_len_q, 1'b0, init_q, rx_ack_q, tx_req_q};

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit: bytes and length first, toggle one cycle later

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_data_q <= '0;
         out_len_q <= 3'h0;
         tx_load_q <= 1'b0;
         tx_req_q <= 1'b0;
      end
      else if (tx_load_q)
      begin
         tx_load_q <= 1'b0;
         tx_req_q <= !tx_req_q;
      end
      else if (reg_wr && reg_addr == `REG_TX && tx_free)
      begin
         out_data_q <= reg_wdata[23:0];
         out_len_q <= reg_wdata[26:24];
         tx_load_q <= 1'b1;
      end
   end

   // Init request level
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         init_q <= 1'b0;
      else if (reg_wr && reg_addr == `REG_CTL)
         init_q <= reg_wdata[0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive: reading the chunk acknowledges it

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rx_ack_q <= 1'b0;
      else if (reg_rd && reg_addr == `REG_RX && rx_avail)
         rx_ack_q <= !rx_ack_q;
   end

   // Read data for one cycle only; unmapped reads return zero
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= 32'h0000_0000;
      else if (!reg_rd)
         reg_rdata <= 32'h0000_0000;
      else
         case (reg_addr)
            `REG_RX:
               reg_rdata <= {rx_avail, 4'h0, img.stat[`STS_LEN_MSB:`STS_LEN_LSB], img.in_data};
            `REG_CTL:
               reg_rdata <= {24'h00_0000, ctrl};
            `REG_STS:
               reg_rdata <= {22'h00_0000, tx_free, rx_avail, img.stat};
            default:
               reg_rdata <= 32'h0000_0000;
         endcase
   end

   assign img.out_data = out_data_q;
   assign img.ctrl = ctrl;
endmodule

// ===== tb/gateway_sva.sv
// Purpose: Checker on the process image link and the gateway line pins.
// Assumes: One clock domain, reset active low.
// Notes: Instantiated beside the interface in the bench.
`timescale 1ns/10ps

module gateway_sva (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire gateway_pkg::image_data_type out_data,
   input wire logic [7:0] ctrl,
   input wire gateway_pkg::image_data_type in_data,
   input wire logic [7:0] stat,
   input wire logic tx_pin,
   input wire logic tx_drive_en
);
   import gateway_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // A chunk is outstanding, and stays so over two samples
   sequence s_rx_waiting;
      stat[1] != ctrl[1];
   endsequence
   sequence s_rx_held;
      s_rx_waiting ##1 s_rx_waiting;
   endsequence

   property p_status_top_zero; stat[7] == 1'b0; endproperty
   property p_ctrl_zero_bits; ctrl[7] == 1'b0 && ctrl[3] == 1'b0; endproperty
   property p_init_ack_low; ctrl[2] |=> !stat[2]; endproperty
   // Skips the edge that releases reset, where the acknowledge flop is still cleared
   property p_init_ack_high; $past(rst_b) && !ctrl[2] |=> stat[2]; endproperty
   property p_init_abort; ctrl[2] |=> !tx_drive_en && tx_pin; endproperty
   property p_tx_ack_copy;
      $changed(stat[0]) |-> stat[0] == $past(ctrl[0]) && !$past(ctrl[2]);
   endproperty
   // Master must not touch a chunk it has not yet seen acknowledged
   property p_tx_hold_out;
      ctrl[0] != stat[0] |-> $stable(out_data) && $stable(ctrl[6:4]);
   endproperty
   property p_rx_from_equal; $changed(stat[1]) |-> $past(stat[1]) == $past(ctrl[1]); endproperty
   property p_rx_count; $changed(stat[1]) |-> stat[6:4] inside {[3'd1:3'd3]}; endproperty
   property p_rx_hold; s_rx_held |-> $stable(in_data) && $stable(stat[6:4]); endproperty
   property p_unused_zero;
      s_rx_waiting |-> (stat[6:4] > 3'd1 || in_data[1] == 8'h00) &&
         (stat[6:4] > 3'd2 || in_data[2] == 8'h00);
   endproperty
   // Idle line is high; a frame opens with a low start bit
   property p_idle_high; !tx_drive_en |-> tx_pin; endproperty
   property p_frame_start; $rose(tx_drive_en) |-> ##[0:1] !tx_pin; endproperty

   a_status_top_zero: assert property (p_status_top_zero) else $error("status bit 7 set");
   a_ctrl_zero_bits: assert property (p_ctrl_zero_bits) else $error("control bit 7 or 3 set");
   a_init_ack_low: assert property (p_init_ack_low) else $error("init ack high in init");
   a_init_ack_high: assert property (p_init_ack_high) else $error("init ack low after init");
   a_init_abort: assert property (p_init_abort) else $error("frame not stopped by init");
   a_tx_ack_copy: assert property (p_tx_ack_copy) else $error("tx ack moved wrongly");
   a_tx_hold_out: assert property (p_tx_hold_out) else $error("out bytes moved while busy");
   a_rx_from_equal: assert property (p_rx_from_equal) else $error("rx toggled unacked");
   a_rx_count: assert property (p_rx_count) else $error("rx count out of range");
   a_rx_hold: assert property (p_rx_hold) else $error("rx chunk changed while pending");
   a_unused_zero: assert property (p_unused_zero) else $error("unused in byte not zero");
   a_idle_high: assert property (p_idle_high) else $error("line low while idle");
   a_frame_start: assert property (p_frame_start) else $error("no start bit");
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the master end facing the serial gateway.
// Assumes: Gateway line looped back to its own receiver.
// Notes: Divisor shortened to 4 during init to keep frames short.
`timescale 1ns/10ps
`include "gateway_regs.svh"

module testbench;
   import gateway_pkg::*;
   localparam int BIT_T = 64;
   logic sys_clk = 1'b0;
   logic rst_b;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] cfg_baud_div = 16'h0004;
   logic [31:0] reg_rdata;
   logic tx_pin;
   logic tx_drive_en;
   logic mon_on = 1'b1;
   logic [31:0] d;
   logic [7:0] exp_tx[$];
   logic [7:0] exp_rx[$];
   logic [2:0] last_n = 3'h0;
   int fails = 0;
   int comparisons = 0;
   integer seed = 32'hfeb7;

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("ERROR at %0t: got %0h expected %0h", $time, g, e); end end

   ////////////////////////////////////////////////////////////////////////////////
   image_if img_bus ();
   image_master image_master_i (.sys_clk(sys_clk), .rst_b(rst_b), .img(img_bus.master),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   // Half duplex loopback: our own frames come back in
   serial_gateway serial_gateway_i (.sys_clk(sys_clk), .rst_b(rst_b), .img(img_bus.device),
      .cfg_baud_div(cfg_baud_div), .rx_pin(tx_pin), .tx_pin(tx_pin), .tx_drive_en(tx_drive_en));
   gateway_sva gateway_sva_i (.sys_clk(sys_clk), .rst_b(rst_b), .out_data(img_bus.out_data),
      .ctrl(img_bus.ctrl), .in_data(img_bus.in_data), .stat(img_bus.stat), .tx_pin(tx_pin),
      .tx_drive_en(tx_drive_en));

   always #4 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic int clip(input logic [2:0] c);
      return (c > 3'd3) ? 3 : int'(c);
   endfunction

   // Register port cycles; read data lands in d
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Poll until the transmit side is free, bounded
   task automatic wait_free();
      int g = 0;
      rd(`REG_STS);
      while (d[9] !== 1'b1 && g < 4000)
      begin
         rd(`REG_STS);
         g++;
      end
      `CHK(d[9], 1'b1)
   endtask

   // Fetch one chunk, if any, and compare against the queue
   task automatic drain_rx();
      int n;
      logic [7:0] b;
      rd(`REG_RX);
      if (d[31] === 1'b1)
      begin
         n = int'(d[26:24]);
         last_n = d[26:24];
         `CHK(n >= 1 && n <= 3, 1'b1)
         for (int k = 0; k < 3; k++)
         begin
            b = (k >= n) ? 8'h00 : (exp_rx.size() > 0) ? exp_rx.pop_front() : 8'hxx;
            `CHK(d[8*k +: 8], b)
         end
      end
   endtask

   task automatic print_verdict();
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Line decoder: samples mid-bit, so it trusts the 16-tick bit time
   initial
   begin
      logic [7:0] w;
      logic [7:0] e;
      forever
      begin
         @(negedge tx_pin);
         repeat (BIT_T / 2) @(posedge sys_clk);
         if (mon_on)
            `CHK(tx_pin, 1'b0)
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_T) @(posedge sys_clk);
            w[i] = tx_pin;
         end
         repeat (BIT_T) @(posedge sys_clk);
         if (mon_on)
         begin
            e = (exp_tx.size() > 0) ? exp_tx.pop_front() : 8'hxx;
            `CHK(tx_pin, 1'b1)
            `CHK(w, e)
         end
      end
   end

   // Main sequence
   initial
   begin
      logic [23:0] bytes;
      logic [2:0] c;
      int g;
      rst_b = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(`REG_STS);
      `CHK(d, 32'h0000_0204)
      rd(4'h2);
      `CHK(d, 32'h0000_0000)
      wr(4'h6, 32'hFFFF_FFFF);
      wr(`REG_CTL, 32'h0000_0001);
      rd(`REG_CTL);
      `CHK(d[7:0], 8'h04)
      rd(`REG_STS);
      `CHK(d[7:0], 8'h00)
      wr(`REG_CTL, 32'h0000_0000);
      rd(`REG_STS);
      `CHK(d, 32'h0000_0204)
      // Random chunks with corner counts; rx drained alongside
      for (int n = 0; n < 24; n++)
      begin
         bytes = 24'($random(seed));
         c = (n == 0) ? 3'd5 : (n == 1) ? 3'd0 : (n == 2) ? 3'd3 : 3'($random(seed));
         wait_free();
         wr(`REG_TX, {5'h00, c, bytes});
         for (int k = 0; k < clip(c); k++)
         begin
            exp_tx.push_back(bytes[8*k +: 8]);
            exp_rx.push_back(bytes[8*k +: 8]);
         end
         if (n == 3)
            wr(`REG_TX, 32'h03AA_BBCC);
         drain_rx();
      end
      g = 0;
      while (exp_rx.size() > 0 && g < 20000)
      begin
         drain_rx();
         g++;
      end
      `CHK(exp_rx.size(), 0)
      `CHK(exp_tx.size(), 0)
      // Init in mid-frame: line released, buffers emptied
      wait_free();
      wr(`REG_TX, 32'h0311_2233);
      g = 0;
      while (tx_drive_en !== 1'b1 && g < 100)
      begin
         @(posedge sys_clk);
         g++;
      end
      repeat (100) @(posedge sys_clk);
      mon_on = 1'b0;
      wr(`REG_CTL, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      `CHK({tx_drive_en, tx_pin}, 2'b01)
      wr(`REG_CTL, 32'h0000_0000);
      repeat (3000) @(posedge sys_clk);
      rd(`REG_STS);
      // Init empties the buffers but leaves the last presented count in place
      `CHK(d & 32'h0000_03FC, 32'h0000_0204 | (32'(last_n) << 4))
      rd(`REG_RX);
      `CHK(d[31], 1'b0)
      print_verdict();
   end

   // Watchdog well past the expected run length
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      fails++;
      print_verdict();
   end
endmodule
